// >>> hdl/gfh_pkg.sv
// Shared constants and types for the generic flash host port
package gfh_pkg;
   localparam int          DATA_W        = 32;
   localparam int          ADDR_W        = 12;
   localparam int          BYTE_W        = 8;
   localparam int          BYTES_PER_WORD = 4;
   localparam logic [31:0] RST_DATA      = 32'h0000_0000;
   localparam int          PROG_TIME_NS  = 200;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W         = 8;
   localparam logic [7:0]  STAT_BUSY_BIT = 8'h00;
   localparam logic [7:0]  STAT_DONE_BIT = 8'h01;
   typedef enum logic [2:0] {
      GFH_IDLE  = 3'b000,
      GFH_BYTE  = 3'b001,
      GFH_ACK   = 3'b011,
      GFH_HOLD  = 3'b010,
      GFH_POLL  = 3'b110
   } gfh_dev_state_t;
   typedef enum logic [1:0] {
      GFH_H_IDLE = 2'b00,
      GFH_H_REQ  = 2'b01,
      GFH_H_WAIT = 2'b11
   } gfh_host_state_t;
endpackage

// >>> hdl/gfh_if.sv
// Host port signals shared by the flash port device end and the host end
interface gfh_if #(parameter int ADDR_W = gfh_pkg::ADDR_W);
   logic              flash_array_choose_low;
   logic              ctrl_reg_choose_low;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       write_data_bus;
   logic [31:0]       rd_data;
   logic              wr_low;
   logic              rd_low;
   logic              ready_low;
   logic              int_low;
   // Flash port end
   modport dev (input flash_array_choose_low, ctrl_reg_choose_low, addr, write_data_bus,
                wr_low, rd_low, output rd_data, ready_low, int_low);
   // Application host end
   modport host (output flash_array_choose_low, ctrl_reg_choose_low, addr, write_data_bus,
                 wr_low, rd_low, input rd_data, ready_low, int_low);
endinterface

// >>> hdl/gfh_dev.sv
// Device end of the generic flash host port with an internal byte-wide flash array
//
// Functional notes
// - All transfers on rising system clock
// - Synchronous 32-bit RAM-like memory port
// - Host selects flash array low
// - Host selects control registers low
// - Address width is a parameter
// - 32-bit write data for program
// - Separate 32-bit read data output
// - Write strobe only with valid data
// - Read strobe only with valid address
// - Ready low on accept or data
// - Interrupt low when program finishes
// - Automatic busy polling, buffered write
// - Byte array packed into 32-bit words
module gfh_dev
   import gfh_pkg::*;
#(
   parameter int ADDR_W = gfh_pkg::ADDR_W,
   parameter int DEPTH  = 256
) (
   // Clock and reset
   input  wire logic CLK_SYS_I,
   input  wire logic RST_I,
   // Host port
   // 32-bit RAM-like port
   gfh_if.dev        PORT,
   // Status
   output logic      BUSY_O
);
   import gfh_pkg::*;

   // Byte-wide flash contents
   // Not reset: a word that was never written reads back unknown
   logic [BYTE_W-1:0]     mem_q [DEPTH];
   gfh_dev_state_t        st_q, st_d;
   logic [1:0]            bcnt_q, bcnt_d;
   logic [31:0]           rdat_q, rdat_d;
   logic [31:0]           wbuf_q, wbuf_d;
   logic [ADDR_W-1:0]     abuf_q, abuf_d;
   logic                  isw_q, isw_d;
   logic                  rdy_q, rdy_d;
   logic                  int_q, int_d;
   logic                  busy_q, busy_d;
   logic                  done_q, done_d;
   logic [CNT_W-1:0]      pcnt_q, pcnt_d;
   logic                  mem_we;
   logic [$clog2(DEPTH)-1:0] mem_a;

   // Byte address within the array for the current byte lane
   // Address bits above the array drop off, so word addresses wrap
   function automatic logic [$clog2(DEPTH)-1:0] byte_addr(input logic [ADDR_W-1:0] a,
                                                          input logic [1:0] lane);
      logic [ADDR_W+1:0] full;
      full = {a, lane};
      return full[$clog2(DEPTH)-1:0];
   endfunction

   // Status word with busy and done at their field positions, spare bits zero
   function automatic logic [31:0] status_word(input logic busy, input logic done);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[STAT_BUSY_BIT[4:0]] = busy;
      w[STAT_DONE_BIT[4:0]] = done;
      return w;
   endfunction

   // Array address and write enable for the current byte lane
   assign mem_a  = byte_addr(abuf_q, bcnt_q);
   assign mem_we = (st_q == GFH_BYTE) && isw_q;

   // Next-state logic for the transfer sequencer
   always_comb begin
      st_d   = st_q;
      bcnt_d = bcnt_q;
      rdat_d = rdat_q;
      wbuf_d = wbuf_q;
      abuf_d = abuf_q;
      isw_d  = isw_q;
      rdy_d  = 1'b1;
      int_d  = int_q;
      busy_d = busy_q;
      done_d = done_q;
      pcnt_d = pcnt_q;
      case (st_q)
         GFH_IDLE: begin
            if (!PORT.ctrl_reg_choose_low && !PORT.rd_low) begin
               // Reading status clears done and withdraws the interrupt
               // Status register read
               rdat_d = status_word(busy_q, done_q);
               done_d = 1'b0;
               int_d  = 1'b1;
               rdy_d  = 1'b0;
               st_d   = GFH_ACK;
            end else if (!PORT.flash_array_choose_low && !busy_q &&
                         (!PORT.rd_low || !PORT.wr_low)) begin
               // Not taken while a program runs; the host simply waits
               // Flash array access
               abuf_d = PORT.addr;
               wbuf_d = PORT.write_data_bus;
               isw_d  = !PORT.wr_low;
               bcnt_d = 2'b00;
               st_d   = GFH_BYTE;
            end
         end

         GFH_BYTE: begin
            // Read bytes shift in from the top, so lane 0 ends in bits 7:0
            // Byte packing
            if (!isw_q) begin
               rdat_d = {mem_q[mem_a], rdat_q[31:8]};
            end
            bcnt_d = bcnt_q + 2'b01;
            if (bcnt_q == 2'b11) begin
               rdy_d = 1'b0;
               st_d  = GFH_ACK;
               if (isw_q) begin
                  busy_d = 1'b1;
                  done_d = 1'b0;
                  pcnt_d = CNT_W'(PROG_CYCLES);
               end
            end
         end

         GFH_ACK: begin
            // Ready stands low for this one cycle only
            // Acknowledge, then move on to wait for the host to release its strobe
            st_d = GFH_HOLD;
         end

         GFH_HOLD: begin
            // Waiting for release keeps a held strobe from being taken twice
            // Host releases strobes
            if (PORT.rd_low && PORT.wr_low) begin
               st_d = busy_q ? GFH_POLL : GFH_IDLE;
            end
         end

         GFH_POLL: begin
            // No access is taken here, so the program time is never cut short
            // Automatic busy polling
            if (pcnt_q == '0) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               int_d  = 1'b0;
               st_d   = GFH_IDLE;
            end else begin
               // Count the program time down
               pcnt_d = pcnt_q - CNT_W'(1);
            end
         end
         default: st_d = GFH_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         st_q   <= GFH_IDLE;
         bcnt_q <= 2'b00;
         rdat_q <= RST_DATA;
         wbuf_q <= RST_DATA;
         abuf_q <= '0;
         isw_q  <= 1'b0;
         // Handshake outputs idle high
         rdy_q  <= 1'b1;
         int_q  <= 1'b1;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         pcnt_q <= '0;
      end else begin
         st_q   <= st_d;
         bcnt_q <= bcnt_d;
         rdat_q <= rdat_d;
         wbuf_q <= wbuf_d;
         abuf_q <= abuf_d;
         isw_q  <= isw_d;
         rdy_q  <= rdy_d;
         int_q  <= int_d;
         busy_q <= busy_d;
         done_q <= done_d;
         pcnt_q <= pcnt_d;
      end
   end

   // Array write, one byte lane per cycle, low lane first
   // Only one transfer runs at a time, so a write never meets a read
   always_ff @(posedge CLK_SYS_I) begin
      if (mem_we) begin
         mem_q[mem_a] <= wbuf_q[8*bcnt_q +: 8];
      end
   end

   assign PORT.rd_data   = rdat_q;
   assign PORT.ready_low = rdy_q;
   // Interrupt level, held until a status read
   assign PORT.int_low   = int_q;
   // Program in progress
   assign BUSY_O         = busy_q;
endmodule

// >>> hdl/gfh_host.sv
// Application host end driving the generic flash host port
module gfh_host
   import gfh_pkg::*;
#(
   parameter int ADDR_W = gfh_pkg::ADDR_W
) (
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              RST_I,
   // User request
   input  wire logic              REQ_I,
   input  wire logic              WRITE_I,
   input  wire logic              CTRL_I,
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [31:0]       WDATA_I,
   // User answer
   output logic                   DONE_O,
   output logic [31:0]            RDATA_O,
   output logic                   IRQ_O,
   // Port
   gfh_if.host                    PORT
);
   import gfh_pkg::*;

   gfh_host_state_t   st_q, st_d;
   logic              fsel_q, fsel_d, csel_q, csel_d, wr_q, wr_d, rd_q, rd_d;
   logic [ADDR_W-1:0] a_q, a_d;
   logic [31:0]       w_q, w_d, r_q, r_d;
   logic              done_q, done_d;
   logic              irq_q, irq_d;

   // Request sequencing
   always_comb begin
      st_d = st_q;
      fsel_d = fsel_q;
      csel_d = csel_q;
      wr_d = wr_q;
      rd_d = rd_q;
      a_d = a_q;
      w_d = w_q;
      r_d = r_q;
      done_d = 1'b0;
      irq_d = !PORT.int_low;
      case (st_q)
         GFH_H_IDLE: begin
            if (REQ_I) begin
               fsel_d = CTRL_I;
               csel_d = !CTRL_I;
               wr_d = !(WRITE_I && !CTRL_I);
               rd_d = WRITE_I && !CTRL_I;
               a_d = ADDR_I;
               w_d = WDATA_I;
               st_d = GFH_H_REQ;
            end
         end
         GFH_H_REQ: begin
            if (!PORT.ready_low) begin
               r_d = PORT.rd_data;
               fsel_d = 1'b1;
               csel_d = 1'b1;
               wr_d = 1'b1;
               rd_d = 1'b1;
               done_d = 1'b1;
               st_d = GFH_H_WAIT;
            end
         end
         GFH_H_WAIT: st_d = GFH_H_IDLE;
         default: st_d = GFH_H_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         st_q <= GFH_H_IDLE;
         fsel_q <= 1'b1;
         csel_q <= 1'b1;
         wr_q <= 1'b1;
         rd_q <= 1'b1;
         a_q <= '0;
         w_q <= RST_DATA;
         r_q <= RST_DATA;
         done_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         fsel_q <= fsel_d;
         csel_q <= csel_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         a_q <= a_d;
         w_q <= w_d;
         r_q <= r_d;
         done_q <= done_d;
         irq_q <= irq_d;
      end
   end

   // Port request signals straight from registers
   assign PORT.flash_array_choose_low = fsel_q;
   assign PORT.ctrl_reg_choose_low    = csel_q;
   assign PORT.wr_low                 = wr_q;
   assign PORT.rd_low                 = rd_q;
   assign PORT.addr                   = a_q;
   assign PORT.write_data_bus         = w_q;
   // User outputs straight from registers
   assign DONE_O  = done_q;
   assign RDATA_O = r_q;
   assign IRQ_O   = irq_q;
endmodule

// >>> bench/gfh_sva.sv
// Concurrent checks on the host port between the device end and the host end
module gfh_sva #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic              CLK_SYS_I,
   input wire logic              RST_I,
   // Host port
   input wire logic              flash_array_choose_low,
   input wire logic              ctrl_reg_choose_low,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0]       write_data_bus,
   input wire logic [31:0]       rd_data,
   input wire logic              wr_low,
   input wire logic              rd_low,
   input wire logic              ready_low,
   input wire logic              int_low
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   // Steps of a transfer as seen on the wires
   sequence s_flash_rd_take; $fell(rd_low) && !flash_array_choose_low; endsequence
   sequence s_ctrl_rd_take; $fell(rd_low) && !ctrl_reg_choose_low; endsequence
   sequence s_write_ack; !wr_low && !flash_array_choose_low && !ready_low; endsequence
   sequence s_status_ack; !rd_low && !ctrl_reg_choose_low && !ready_low; endsequence
   a_ready_one_pulse:
      assert property ($fell(ready_low) |=> ready_low) else $error("ready held too long");
   a_ready_has_cause:
      assert property (!ready_low |-> (!rd_low || !wr_low)) else $error("ready without strobe");
   a_status_answer_time:
      assert property (s_ctrl_rd_take |-> ##[1:3] $fell(ready_low)) else $error("status late");
   a_flash_answer_time:
      assert property (s_flash_rd_take |-> ##[5:40] $fell(ready_low)) else $error("read late");
   a_request_held:
      assert property ((!rd_low || !wr_low) && ready_low |=> $stable(addr) && $stable(rd_low)
         && $stable(wr_low) && $stable(write_data_bus) && $stable(flash_array_choose_low)
         && $stable(ctrl_reg_choose_low)) else $error("request changed early");
   a_selects_exclusive:
      assert property ((flash_array_choose_low || ctrl_reg_choose_low) && (rd_low || wr_low))
         else $error("both selects or strobes low");
   a_int_after_write:
      assert property (s_write_ack |-> ##[15:40] !int_low) else $error("no completion interrupt");
   a_int_cleared:
      assert property (s_status_ack |-> ##[1:2] int_low) else $error("interrupt not cleared");
   a_status_spare_zero:
      assert property (s_status_ack |-> rd_data[31:2] == 30'h0) else $error("status bits set");
endmodule

// >>> bench/gfh_bench.sv
// Self-checking bench joining the device end and the host end of the flash host port
module gfh_bench
   import gfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys, rst, req, wr, ctrl, done, irq, busy;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wdata, rdata, rd;
   int                bad_count, cmp_count, cyc;
   gfh_if port_if ();
   gfh_dev u_gfh_dev (.CLK_SYS_I(clk_sys), .RST_I(rst), .PORT(port_if), .BUSY_O(busy));
   gfh_host u_gfh_host (.CLK_SYS_I(clk_sys), .RST_I(rst), .REQ_I(req), .WRITE_I(wr),
      .CTRL_I(ctrl), .ADDR_I(addr), .WDATA_I(wdata), .DONE_O(done), .RDATA_O(rdata),
      .IRQ_O(irq), .PORT(port_if));
   gfh_sva #(.ADDR_W(ADDR_W)) u_gfh_sva (.CLK_SYS_I(clk_sys), .RST_I(rst),
      .flash_array_choose_low(port_if.flash_array_choose_low),
      .ctrl_reg_choose_low(port_if.ctrl_reg_choose_low), .addr(port_if.addr),
      .write_data_bus(port_if.write_data_bus), .rd_data(port_if.rd_data),
      .wr_low(port_if.wr_low), .rd_low(port_if.rd_low), .ready_low(port_if.ready_low),
      .int_low(port_if.int_low));
   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Report counts and end the run
   task automatic print_verdict();
      $display("counts: %0d mismatches, %0d comparisons", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One user request; holds it until the port strobes show, then waits for done
   task automatic xfer(input logic w, input logic c, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
      @(negedge clk_sys);
      req = 1'b1;
      wr = w;
      ctrl = c;
      addr = a;
      wdata = d;
      cyc = 0;
      while (done !== 1'b1) begin
         @(negedge clk_sys);
         if (port_if.rd_low === 1'b0 || port_if.wr_low === 1'b0)
            req = 1'b0;
         cyc++;
         if (cyc > 200) begin
            bad_count++;
            $display("mismatch at %0t: transfer never finished", $time);
            print_verdict();
         end
      end
      rd = rdata;
   endtask
   // Write, read back under the program stall, then interrupt and status
   task automatic t_write_read();
      xfer(1'b0, 1'b1, 12'h000, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      xfer(1'b1, 1'b0, 12'h000, 32'h1122_3344);
      check({31'h0, busy}, 32'h0000_0001);
      xfer(1'b0, 1'b0, 12'h000, 32'h0000_0000);
      check(rd, 32'h1122_3344);
      check(32'(cyc >= PROG_CYCLES), 32'h0000_0001);
      check({31'h0, irq}, 32'h0000_0001);
      xfer(1'b0, 1'b1, 12'h005, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      check({31'h0, irq}, 32'h0000_0000);
      xfer(1'b0, 1'b1, 12'h000, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask
   // Back-to-back writes, last word and wrap of the byte array
   task automatic t_boundary();
      xfer(1'b1, 1'b0, 12'h03F, 32'hDEAD_BEEF);
      xfer(1'b1, 1'b0, 12'h001, 32'h0102_0304);
      xfer(1'b0, 1'b0, 12'h03F, 32'h0000_0000);
      check(rd, 32'hDEAD_BEEF);
      xfer(1'b0, 1'b0, 12'h03F, 32'h0000_0000);
      check(rd, 32'hDEAD_BEEF);
      xfer(1'b0, 1'b0, 12'h040, 32'h0000_0000);
      check(rd, 32'h1122_3344);
      xfer(1'b0, 1'b0, 12'h041, 32'h0000_0000);
      check(rd, 32'h0102_0304);
      xfer(1'b0, 1'b1, 12'h000, 32'h0000_0000);
      check(rd, 32'h0000_0002);
   endtask
   // Reset, scenarios, verdict
   initial begin
      rst = 1'b1;
      req = 1'b0;
      wr = 1'b0;
      ctrl = 1'b0;
      addr = '0;
      wdata = 32'h0000_0000;
      bad_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      t_write_read();
      t_boundary();
      print_verdict();
   end
endmodule
